/* File: ftc_regs.sv */
`timescale 1ns/1ps
// Function
// - Lock blocks pin/tach/input register except bits 4,5
// - Pin field picks fan-on, overtemp or cpu-hot role
// - Failsafe_full_cooling plus cpu-hot forces full fan duty
// - Bits 4,5 enable continuous tach on a/b
// - Bits 6,7 pick resistor sensor per input
// - One-channel mode converts only selected channel
// - Bit 3 switches round-robin to one channel
// - Floor clamp keeps each fan above minimum
// - Channel register bits 6,7 read zero always
// - Several sources selected: highest demand wins, input b only as resistor sensor
// - Source bits map to four temperature inputs
// - Highest override bit 7..4 wins over lower
// - Two fan control registers reset to 0x0C
// - Low bits one packs four two-bit pairs
// - Low bits two: local pair, rest zero
// - Voltage readings give upper eight bits
// - Temperature readings give upper eight bits
// - Low-bit read freezes it and its readings
// - Lock is sticky until power cycle
module ftc_regs #(
  parameter int TACH_SLOW_CYC = ftc_pkg::TACH_SLOW_CYC,
  parameter int TACH_FAST_CYC = ftc_pkg::TACH_FAST_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Register port
  input wire ftc_pkg::ftc_req_t req_i,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  // Global lock from the main configuration register
  input wire logic lock_i,
  // Multi-function pin
  input wire logic multi_pin_i,
  output logic multi_pin_o,
  output logic multi_pin_oe_b_o,
  input wire logic fan_a_on_req_i,
  input wire logic overtemp_req_i,
  output logic cpu_hot_o,
  // Tach measurement control
  output logic tach_meas_tick_o,
  output logic continuous_speed_meas_a_o,
  output logic continuous_speed_meas_b_o,
  // Converter control and results
  output logic input_a_resistor_sensor_sel_o,
  output logic input_b_resistor_sensor_sel_o,
  output logic one_channel_conversion_o,
  output logic [2:0] conversion_channel_o,
  input wire logic conv_done_i,
  input wire logic [ftc_pkg::NUM_CH-1:0] res_valid_i,
  input wire logic [ftc_pkg::NUM_CH*ftc_pkg::RES_W-1:0] res_data_i,
  // Fan drive
  input wire ftc_pkg::ftc_src_t fan_a_src_i,
  input wire ftc_pkg::ftc_src_t fan_b_src_i,
  input wire ftc_pkg::ftc_lim_t fan_a_lim_i,
  input wire ftc_pkg::ftc_lim_t fan_b_lim_i,
  output logic [7:0] fan_a_drive_level_o,
  output logic [7:0] fan_b_drive_level_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  logic [7:0] pin_tach_input_config_ff;
  logic [7:0] channel_select_fan_floor_config_ff;
  logic [7:0] fan1_auto_control_config_ff;
  logic [7:0] fan2_auto_control_config_ff;
  logic lock_ff;
  logic [ftc_pkg::RES_W-1:0] res_ff [ftc_pkg::NUM_CH];
  logic [ftc_pkg::NUM_CH-1:0] frz_ff;
  logic grp1_frz;
  logic grp2_frz;
  logic rd_low1;
  logic rd_low2;
  logic [7:0] nxt_rd_data;
  logic [7:0] low_bits_one;
  logic [7:0] low_bits_two;
  logic wr_pin_cfg;

  assign rd_low1 = req_i.rd && req_i.addr == ftc_pkg::ADDR_LOW_BITS_ONE;
  assign rd_low2 = req_i.rd && req_i.addr == ftc_pkg::ADDR_LOW_BITS_TWO;
  assign wr_pin_cfg = req_i.wr && req_i.addr == ftc_pkg::ADDR_PIN_TACH_INPUT_CFG;

  // Power-on reset is the only way out of lock
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      lock_ff <= 1'b0;
    end else if (lock_i) begin
      lock_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pin_tach_input_config_ff <= ftc_pkg::RST_PIN_TACH_INPUT_CFG;
    end else if (wr_pin_cfg) begin
      if (lock_ff) begin
        pin_tach_input_config_ff <= (pin_tach_input_config_ff & ~ftc_pkg::UNLOCKED_MASK)
                                    | (req_i.wdata & ftc_pkg::UNLOCKED_MASK);
      end else begin
        pin_tach_input_config_ff <= req_i.wdata;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      channel_select_fan_floor_config_ff <= ftc_pkg::RST_CHSEL_FLOOR_CFG;
    end else if (req_i.wr && req_i.addr == ftc_pkg::ADDR_CHSEL_FLOOR_CFG) begin
      channel_select_fan_floor_config_ff <= req_i.wdata & ftc_pkg::CHSEL_FLOOR_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      fan1_auto_control_config_ff <= ftc_pkg::RST_FAN_AUTO_CFG;
      fan2_auto_control_config_ff <= ftc_pkg::RST_FAN_AUTO_CFG;
    end else if (req_i.wr) begin
      if (req_i.addr == ftc_pkg::ADDR_FAN1_AUTO_CFG) begin
        fan1_auto_control_config_ff <= req_i.wdata;
      end else if (req_i.addr == ftc_pkg::ADDR_FAN2_AUTO_CFG) begin
        fan2_auto_control_config_ff <= req_i.wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Readings and freeze

  // A group stays frozen until every reading it covers has been read
  assign grp1_frz = |frz_ff[ftc_pkg::CH_LOCAL_IDX-1:0];
  assign grp2_frz = frz_ff[ftc_pkg::CH_LOCAL_IDX];

  generate
    for (genvar c = 0; c < ftc_pkg::NUM_CH; c++) begin : g_ch
      localparam logic [7:0] CH_ADDR = ftc_pkg::ADDR_INPUT1_HIGH + 8'(c);
      logic grp_frz;
      logic grp_rd;
      logic rd_high;
      if (c == ftc_pkg::CH_LOCAL_IDX) begin : g_two
        assign grp_frz = grp2_frz;
        assign grp_rd = rd_low2;
      end else begin : g_one
        assign grp_frz = grp1_frz;
        assign grp_rd = rd_low1;
      end
      assign rd_high = req_i.rd && req_i.addr == CH_ADDR;

      // Set by the low-bit read wins over the clear by a high read
      always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
          frz_ff[c] <= 1'b0;
        end else if (grp_rd) begin
          frz_ff[c] <= 1'b1;
        end else if (rd_high) begin
          frz_ff[c] <= 1'b0;
        end
      end

      // Result arriving in the freezing read cycle is also held back
      always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
          res_ff[c] <= '0;
        end else if (res_valid_i[c] && !grp_frz && !grp_rd) begin
          res_ff[c] <= res_data_i[c*ftc_pkg::RES_W +: ftc_pkg::RES_W];
        end
      end
    end
  endgenerate

  assign low_bits_one = {res_ff[0][1:0], res_ff[1][1:0], res_ff[2][1:0], res_ff[3][1:0]};
  assign low_bits_two = {6'h00, res_ff[ftc_pkg::CH_LOCAL_IDX][1:0]};

  ////////////////////////////////////////////////////////////////////////////
  // Read port

  always_comb begin
    if (req_i.addr == ftc_pkg::ADDR_PIN_TACH_INPUT_CFG) begin
      nxt_rd_data = pin_tach_input_config_ff;
    end else if (req_i.addr == ftc_pkg::ADDR_CHSEL_FLOOR_CFG) begin
      nxt_rd_data = channel_select_fan_floor_config_ff;
    end else if (req_i.addr == ftc_pkg::ADDR_FAN1_AUTO_CFG) begin
      nxt_rd_data = fan1_auto_control_config_ff;
    end else if (req_i.addr == ftc_pkg::ADDR_FAN2_AUTO_CFG) begin
      nxt_rd_data = fan2_auto_control_config_ff;
    end else if (req_i.addr == ftc_pkg::ADDR_LOW_BITS_ONE) begin
      nxt_rd_data = low_bits_one;
    end else if (req_i.addr == ftc_pkg::ADDR_LOW_BITS_TWO) begin
      nxt_rd_data = low_bits_two;
    end else if (req_i.addr >= ftc_pkg::ADDR_INPUT1_HIGH && req_i.addr <= ftc_pkg::ADDR_LOCAL_HIGH) begin
      nxt_rd_data = res_ff[3'(req_i.addr - ftc_pkg::ADDR_INPUT1_HIGH)][9:2];
    end else begin
      nxt_rd_data = 8'h00;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rd_data_o <= 8'h00;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= req_i.rd;
      if (req_i.rd) begin
        rd_data_o <= nxt_rd_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Multi-function pin

  logic [1:0] pin_func;
  assign pin_func = pin_tach_input_config_ff[ftc_pkg::PIN_FUNC_LSB +: 2];

  // Overtemp and cpu-hot are active low on the wire
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      multi_pin_o <= 1'b1;
      multi_pin_oe_b_o <= 1'b1;
      cpu_hot_o <= 1'b0;
    end else begin
      cpu_hot_o <= pin_func[1] && !multi_pin_i;
      if (pin_func == ftc_pkg::PIN_FAN_ON) begin
        multi_pin_o <= fan_a_on_req_i;
        multi_pin_oe_b_o <= 1'b0;
      end else if (pin_func == ftc_pkg::PIN_OVERTEMP) begin
        multi_pin_o <= !overtemp_req_i;
        multi_pin_oe_b_o <= 1'b0;
      end else begin
        multi_pin_o <= 1'b1;
        multi_pin_oe_b_o <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tach timing and converter control

  logic fast_tach;
  logic [31:0] tach_cnt_ff;
  assign fast_tach = pin_tach_input_config_ff[ftc_pkg::FAST_TACH_BIT];
  assign continuous_speed_meas_a_o = pin_tach_input_config_ff[ftc_pkg::CONT_A_BIT];
  assign continuous_speed_meas_b_o = pin_tach_input_config_ff[ftc_pkg::CONT_B_BIT];
  assign input_a_resistor_sensor_sel_o = pin_tach_input_config_ff[ftc_pkg::INPUT_A_RSEL_BIT];
  assign input_b_resistor_sensor_sel_o = pin_tach_input_config_ff[ftc_pkg::INPUT_B_RSEL_BIT];

  // Period change takes effect at the next tick, not mid-count
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      tach_cnt_ff <= 32'(TACH_SLOW_CYC - 1);
      tach_meas_tick_o <= 1'b0;
    end else begin
      tach_meas_tick_o <= tach_cnt_ff == 32'h0;
      if (tach_cnt_ff == 32'h0) begin
        tach_cnt_ff <= fast_tach ? 32'(TACH_FAST_CYC - 1) : 32'(TACH_SLOW_CYC - 1);
      end else begin
        tach_cnt_ff <= tach_cnt_ff - 32'h1;
      end
    end
  end

  logic [2:0] rr_ch_ff;
  assign one_channel_conversion_o = channel_select_fan_floor_config_ff[ftc_pkg::ONE_CH_BIT];

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rr_ch_ff <= 3'h0;
    end else if (conv_done_i && !one_channel_conversion_o) begin
      rr_ch_ff <= (rr_ch_ff == ftc_pkg::RR_LAST) ? 3'h0 : rr_ch_ff + 3'h1;
    end
  end

  assign conversion_channel_o = one_channel_conversion_o ? channel_select_fan_floor_config_ff[2:0] : rr_ch_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Fan drive

  logic full_cooling;
  logic [7:0] nxt_fan_a;
  logic [7:0] nxt_fan_b;
  assign full_cooling = pin_tach_input_config_ff[ftc_pkg::FAILSAFE_FULL_COOLING_BIT] && cpu_hot_o;

  ftc_fan_ctl u_fan_a (
    .auto_cfg_i(fan1_auto_control_config_ff),
    .floor_clamp_i(channel_select_fan_floor_config_ff[ftc_pkg::FLOOR_A_BIT]),
    .input_b_rsel_i(input_b_resistor_sensor_sel_o),
    .full_cooling_i(full_cooling),
    .src_i(fan_a_src_i),
    .lim_i(fan_a_lim_i),
    .drive_o(nxt_fan_a)
  );

  ftc_fan_ctl u_fan_b (
    .auto_cfg_i(fan2_auto_control_config_ff),
    .floor_clamp_i(channel_select_fan_floor_config_ff[ftc_pkg::FLOOR_B_BIT]),
    .input_b_rsel_i(input_b_resistor_sensor_sel_o),
    .full_cooling_i(full_cooling),
    .src_i(fan_b_src_i),
    .lim_i(fan_b_lim_i),
    .drive_o(nxt_fan_b)
  );

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      fan_a_drive_level_o <= 8'h00;
      fan_b_drive_level_o <= 8'h00;
    end else begin
      fan_a_drive_level_o <= nxt_fan_a;
      fan_b_drive_level_o <= nxt_fan_b;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  chk_lock_holds: assert property (lock_ff && wr_pin_cfg |=>
    (pin_tach_input_config_ff & ~ftc_pkg::UNLOCKED_MASK) == ($past(pin_tach_input_config_ff) & ~ftc_pkg::UNLOCKED_MASK))
    else $error("locked bits changed");
  chk_cont_writable: assert property (wr_pin_cfg |=>
    continuous_speed_meas_a_o == $past(req_i.wdata[ftc_pkg::CONT_A_BIT]))
    else $error("continuous tach bit not written");
  chk_lock_sticky: assert property (lock_ff |=> lock_ff) else $error("lock dropped");
  chk_pin_input: assert property (pin_func[1] |=> multi_pin_oe_b_o) else $error("pin driven in input role");
  chk_failsafe_full_cooling_full: assert property (full_cooling |=> fan_a_drive_level_o == ftc_pkg::FULL_DUTY
    && fan_b_drive_level_o == ftc_pkg::FULL_DUTY) else $error("failsafe_full_cooling not at full duty");
  chk_tach_fast: assert property (tach_cnt_ff == 32'h0 && fast_tach |=>
    tach_cnt_ff == 32'(TACH_FAST_CYC - 1) ##1 tach_meas_tick_o == 1'b0) else $error("fast tach period wrong");
  chk_single_ch: assert property (one_channel_conversion_o |->
    conversion_channel_o == channel_select_fan_floor_config_ff[2:0]) else $error("single channel ignored");
  chk_floor_clamp: assert property (channel_select_fan_floor_config_ff[ftc_pkg::FLOOR_A_BIT]
    && $stable(fan_a_lim_i.floor) |=> fan_a_drive_level_o >= fan_a_lim_i.floor) else $error("fan below floor");
  chk_unused_zero: assert property (channel_select_fan_floor_config_ff[7:6] == 2'h0) else $error("unused bits set");
  chk_auto_reset: assert property ($rose(rst_b_i) |-> fan1_auto_control_config_ff == ftc_pkg::RST_FAN_AUTO_CFG
    && fan2_auto_control_config_ff == ftc_pkg::RST_FAN_AUTO_CFG) else $error("auto control reset wrong");
  chk_max_prio: assert property (fan1_auto_control_config_ff[ftc_pkg::MAX_BIT] && !full_cooling
    && !channel_select_fan_floor_config_ff[ftc_pkg::FLOOR_A_BIT] |=> fan_a_drive_level_o == $past(fan_a_lim_i.max))
    else $error("max override lost");
  chk_low_two: assert property (rd_low2 |=> rd_data_o[7:2] == 6'h00) else $error("low bits two upper set");
  chk_freeze_hold: assert property (rd_low1 |=> grp1_frz && $stable(low_bits_one))
    else $error("freeze not taken");
  chk_freeze_release: assert property (grp1_frz && req_i.rd && req_i.addr == ftc_pkg::ADDR_REMOTE1_HIGH
    && !rd_low1 |=> !frz_ff[3]) else $error("freeze not released");
  chk_high_read: assert property (req_i.rd && req_i.addr == ftc_pkg::ADDR_REMOTE1_HIGH |=>
    rd_data_o == $past(res_ff[3][9:2])) else $error("remote reading wrong");

  cov_locked_write: cover property (lock_ff && wr_pin_cfg);
  cov_freeze_cycle: cover property (rd_low1 ##[1:20] !grp1_frz);
  cov_failsafe_full_cooling: cover property (full_cooling);

endmodule : ftc_regs

/* File: ftc_pkg.sv */
package ftc_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_PIN_TACH_INPUT_CFG = 8'h02;
  localparam logic [7:0] ADDR_CHSEL_FLOOR_CFG = 8'h03;
  localparam logic [7:0] ADDR_FAN1_AUTO_CFG = 8'h05;
  localparam logic [7:0] ADDR_FAN2_AUTO_CFG = 8'h06;
  localparam logic [7:0] ADDR_LOW_BITS_ONE = 8'h08;
  localparam logic [7:0] ADDR_LOW_BITS_TWO = 8'h09;
  localparam logic [7:0] ADDR_INPUT1_HIGH = 8'h0A;
  localparam logic [7:0] ADDR_INPUT2_HIGH = 8'h0B;
  localparam logic [7:0] ADDR_SUPPLY_HIGH = 8'h0C;
  localparam logic [7:0] ADDR_REMOTE1_HIGH = 8'h0D;
  localparam logic [7:0] ADDR_LOCAL_HIGH = 8'h0E;

  // Reset values
  localparam logic [7:0] RST_PIN_TACH_INPUT_CFG = 8'hC0;
  localparam logic [7:0] RST_CHSEL_FLOOR_CFG = 8'h00;
  localparam logic [7:0] RST_FAN_AUTO_CFG = 8'h0C;
  localparam logic [7:0] RST_READING = 8'h00;

  // Pin/tach/input register fields
  localparam int PIN_FUNC_LSB = 0;
  localparam int FAILSAFE_FULL_COOLING_BIT = 2;
  localparam int FAST_TACH_BIT = 3;
  localparam int CONT_A_BIT = 4;
  localparam int CONT_B_BIT = 5;
  localparam int INPUT_A_RSEL_BIT = 6;
  localparam int INPUT_B_RSEL_BIT = 7;
  // Bits that stay writable under lock
  localparam logic [7:0] UNLOCKED_MASK = 8'h30;
  localparam logic [1:0] PIN_FAN_ON = 2'h0;
  localparam logic [1:0] PIN_OVERTEMP = 2'h1;

  // Channel select / floor register fields
  localparam int ONE_CH_BIT = 3;
  localparam int FLOOR_A_BIT = 4;
  localparam int FLOOR_B_BIT = 5;
  localparam logic [7:0] CHSEL_FLOOR_MASK = 8'h3F;
  localparam logic [2:0] CH_REMOTE1 = 3'h3;
  localparam logic [2:0] CH_LOCAL = 3'h4;
  localparam logic [2:0] CH_REMOTE2 = 3'h5;
  localparam logic [2:0] RR_LAST = 3'h5;

  // Fan auto control fields
  localparam int AUTO_SRC_B_BIT = 1;
  localparam int MANUAL_BIT = 4;
  localparam int FLOOR_BIT = 5;
  localparam int SPINUP_BIT = 6;
  localparam int MAX_BIT = 7;
  localparam logic [7:0] FULL_DUTY = 8'hFF;

  // Reading channels: 0 input a, 1 input b, 2 supply, 3 remote 1, 4 local
  localparam int NUM_CH = 5;
  localparam int CH_LOCAL_IDX = 4;
  localparam int RES_W = 10;

  // Tach measurement period
  localparam int CLK_MHZ = 100;
  localparam int TACH_SLOW_MS = 1000;
  localparam int TACH_FAST_MS = 250;
  localparam int TACH_SLOW_CYC = TACH_SLOW_MS * 1000 * CLK_MHZ;
  localparam int TACH_FAST_CYC = TACH_FAST_MS * 1000 * CLK_MHZ;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ftc_req_t;

  // Speed demanded by each temperature source, bit order of the control field
  typedef struct packed {
    logic [7:0] on_die;
    logic [7:0] diode_a;
    logic [7:0] input_b;
    logic [7:0] input_a;
  } ftc_src_t;

  typedef struct packed {
    logic [7:0] max;
    logic [7:0] spinup;
    logic [7:0] floor;
    logic [7:0] manual;
  } ftc_lim_t;

endpackage : ftc_pkg

/* File: ftc_fan_ctl.sv */
`timescale 1ns/1ps
module ftc_fan_ctl (
  // Configuration
  input wire logic [7:0] auto_cfg_i,
  input wire logic floor_clamp_i,
  input wire logic input_b_rsel_i,
  input wire logic full_cooling_i,
  // Demands
  input wire ftc_pkg::ftc_src_t src_i,
  input wire ftc_pkg::ftc_lim_t lim_i,
  // Result
  output logic [7:0] drive_o
);

  logic [7:0] dem [4];
  logic [7:0] auto_lvl;
  logic [7:0] base_lvl;

  assign dem[0] = src_i.input_a;
  assign dem[1] = src_i.input_b;
  assign dem[2] = src_i.diode_a;
  assign dem[3] = src_i.on_die;

  always_comb begin
    auto_lvl = 8'h00;
    for (int i = 0; i < 4; i++) begin
      // Second input only counts when wired as a resistor sensor
      if (auto_cfg_i[i] && (i != ftc_pkg::AUTO_SRC_B_BIT || input_b_rsel_i) && dem[i] > auto_lvl) begin
        auto_lvl = dem[i];
      end
    end
  end

  always_comb begin
    if (auto_cfg_i[ftc_pkg::MAX_BIT]) begin
      base_lvl = lim_i.max;
    end else if (auto_cfg_i[ftc_pkg::SPINUP_BIT]) begin
      base_lvl = lim_i.spinup;
    end else if (auto_cfg_i[ftc_pkg::FLOOR_BIT]) begin
      base_lvl = lim_i.floor;
    end else if (auto_cfg_i[ftc_pkg::MANUAL_BIT]) begin
      base_lvl = lim_i.manual;
    end else begin
      base_lvl = auto_lvl;
    end
  end

  always_comb begin
    if (full_cooling_i) begin
      drive_o = ftc_pkg::FULL_DUTY;
    end else if (floor_clamp_i && base_lvl < lim_i.floor) begin
      drive_o = lim_i.floor;
    end else begin
      drive_o = base_lvl;
    end
  end

endmodule : ftc_fan_ctl

/* File: ftc_host_model.sv */
`timescale 1ns/1ps
module ftc_host_model (
  // Clock
  input wire logic clk_i,
  // Answer
  input wire logic [7:0] rd_data_i,
  input wire logic rd_valid_i,
  // Request
  output ftc_pkg::ftc_req_t req_o
);
  initial req_o = '0;
  //////////////////////////////
  // Request held one edge, dropped at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_i);
    req_o <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d = 8'h00;
    @(posedge clk_i);
    req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_i);
    req_o <= '0;
    // Valid is a one-cycle pulse, so look every cycle
    for (int i = 0; i < 4 && !ok; i++) begin
      @(negedge clk_i);
      if (rd_valid_i === 1'b1) begin
        ok = 1'b1;
        d = rd_data_i;
      end
    end
  endtask : rd
endmodule : ftc_host_model

/* File: ftc_regs_bench.sv */
`timescale 1ns/1ps
module ftc_regs_bench;
  localparam logic [7:0] RA [12] = '{8'h02, 8'h03, 8'h05, 8'h06, 8'h07, 8'h08,
    8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E};
  localparam logic [7:0] RV [12] = '{8'hC0, 8'h00, 8'h0C, 8'h0C, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] CFG [7] = '{8'hF0, 8'h7C, 8'h3F, 8'h1F, 8'h0C, 8'h05, 8'h02};
  localparam logic [7:0] EXP [7] = '{8'h90, 8'h70, 8'h60, 8'h11, 8'h50, 8'h30, 8'h20};
  int fail_count;
  int n_compared;
  logic clk_i, rst_b_i, lock_i, pin_i, on_req, ovt_req, conv_done;
  logic rd_valid, pin_o, oe_b, cpu_hot, cont_a, cont_b, sel_a, sel_b, one_ch, ok, tick;
  logic [4:0] res_valid;
  logic [49:0] res_data;
  logic [7:0] rd_data, drv_a, drv_b, q;
  logic [2:0] chan;
  ftc_pkg::ftc_req_t req;
  ftc_pkg::ftc_src_t src;
  ftc_pkg::ftc_lim_t lim;
  //////////////////////////////
  ftc_host_model u_host (.clk_i(clk_i), .rd_data_i(rd_data), .rd_valid_i(rd_valid), .req_o(req));
  // Short tach periods keep the run brief
  ftc_regs #(.TACH_SLOW_CYC(40), .TACH_FAST_CYC(10)) u_dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(req), .rd_data_o(rd_data),
    .rd_valid_o(rd_valid), .lock_i(lock_i), .multi_pin_i(pin_i), .multi_pin_o(pin_o),
    .multi_pin_oe_b_o(oe_b), .fan_a_on_req_i(on_req), .overtemp_req_i(ovt_req),
    .cpu_hot_o(cpu_hot), .tach_meas_tick_o(tick), .continuous_speed_meas_a_o(cont_a),
    .continuous_speed_meas_b_o(cont_b), .input_a_resistor_sensor_sel_o(sel_a),
    .input_b_resistor_sensor_sel_o(sel_b), .one_channel_conversion_o(one_ch),
    .conversion_channel_o(chan), .conv_done_i(conv_done), .res_valid_i(res_valid),
    .res_data_i(res_data), .fan_a_src_i(src), .fan_b_src_i(src), .fan_a_lim_i(lim),
    .fan_b_lim_i(lim), .fan_a_drive_level_o(drv_a), .fan_b_drive_level_o(drv_b));
  //////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic print_verdict;
    if (fail_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    u_host.rd(a, q, ok);
    if (ok !== 1'b1) begin
      fail_count++;
      $display("wrong value rd_valid_o expected 1 seen 0");
      print_verdict();
    end else begin
      chk($sformatf("reg %h", a), exp, q);
    end
  endtask : rd_chk
  task automatic settle;
    repeat (3) @(posedge clk_i);
    #1;
  endtask : settle
  task automatic pulse(input logic [49:0] nxt);
    @(posedge clk_i);
    res_valid <= 5'h1F;
    @(posedge clk_i);
    res_valid <= 5'h00;
    res_data <= nxt;
  endtask : pulse
  // Cycles between two tick pulses; a missing tick counts as a mismatch
  task automatic tick_gap(input logic [7:0] exp);
    int cyc;
    int seen;
    cyc = 0;
    seen = 0;
    for (int n = 0; n < 100 && seen < 2; n++) begin
      @(posedge clk_i);
      #1;
      cyc++;
      if (tick === 1'b1) begin
        if (seen == 1) chk("tach period", exp, 8'(cyc));
        seen++;
        cyc = 0;
      end
    end
    if (seen < 2) chk("tach tick", 8'h01, 8'h00);
  endtask : tick_gap
  //////////////////////////////
  initial begin
    fail_count = 0;
    n_compared = 0;
    rst_b_i = 1'b0;
    lock_i = 1'b0;
    pin_i = 1'b1;
    on_req = 1'b0;
    ovt_req = 1'b0;
    conv_done = 1'b0;
    res_valid = 5'h00;
    res_data = {10'h397, 10'h352, 10'h30D, 10'h2CA, 10'h287};
    src = '{on_die: 8'h50, diode_a: 8'h30, input_b: 8'h20, input_a: 8'h10};
    lim = '{max: 8'h90, spinup: 8'h70, floor: 8'h60, manual: 8'h11};
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1'b1;
    foreach (RA[i]) rd_chk(RA[i], RV[i]);
    chk("input sel", 8'h03, {6'h00, sel_b, sel_a});
    u_host.wr(8'h03, 8'hFF);
    rd_chk(8'h03, 8'h3F);
    for (int c = 3; c <= 5; c++) begin
      u_host.wr(8'h03, 8'h08 | 8'(c));
      settle();
      chk("channel", 8'(c), {5'h00, chan});
      chk("one channel", 8'h01, {7'h00, one_ch});
    end
    u_host.wr(8'h03, 8'h00);
    // Seven conversions walk codes 0..5 and wrap to 1
    @(posedge clk_i);
    conv_done <= 1'b1;
    repeat (7) @(posedge clk_i);
    conv_done <= 1'b0;
    settle();
    chk("round robin", 8'h01, {5'h00, chan});
    // Every override over all lower override bits, then source maxima
    for (int f = 0; f < 2; f++) begin
      for (int k = 0; k < 7; k++) begin
        u_host.wr(8'h05 + 8'(f), CFG[k]);
        settle();
        chk("fan drive", EXP[k], f ? drv_b : drv_a);
      end
    end
    u_host.wr(8'h03, 8'h10);
    settle();
    chk("drive a floor", 8'h60, drv_a);
    chk("drive b", 8'h20, drv_b);
    @(posedge clk_i);
    on_req <= 1'b1;
    ovt_req <= 1'b1;
    settle();
    chk("fan on pin", 8'h01, {6'h00, oe_b, pin_o});
    u_host.wr(8'h02, 8'hC1);
    settle();
    chk("overtemp pin", 8'h00, {6'h00, oe_b, pin_o});
    @(posedge clk_i);
    pin_i <= 1'b0;
    u_host.wr(8'h02, 8'hC6);
    settle();
    chk("cpu hot", 8'h03, {6'h00, oe_b, cpu_hot});
    chk("failsafe_full_cooling a", 8'hFF, drv_a);
    chk("failsafe_full_cooling b", 8'hFF, drv_b);
    @(posedge clk_i);
    pin_i <= 1'b1;
    // Low bits first, then new results must not show
    pulse({5{10'h155}});
    rd_chk(8'h08, 8'hE6);
    rd_chk(8'h09, 8'h03);
    pulse({5{10'h155}});
    rd_chk(8'h0D, 8'hD4);
    rd_chk(8'h0A, 8'hA1);
    rd_chk(8'h0B, 8'hB2);
    rd_chk(8'h0C, 8'hC3);
    rd_chk(8'h0E, 8'hE5);
    pulse({5{10'h155}});
    rd_chk(8'h0A, 8'h55);
    rd_chk(8'h0E, 8'h55);
    rd_chk(8'h08, 8'h55);
    // Slow period with the bench's short counts, then fast after reload
    tick_gap(8'h28);
    u_host.wr(8'h02, 8'h08);
    tick_gap(8'h0A);
    u_host.wr(8'h02, 8'h00);
    @(posedge clk_i);
    lock_i <= 1'b1;
    @(posedge clk_i);
    lock_i <= 1'b0;
    u_host.wr(8'h02, 8'hFF);
    rd_chk(8'h02, 8'h30);
    chk("continuous", 8'h03, {6'h00, cont_b, cont_a});
    chk("input sel locked", 8'h00, {6'h00, sel_b, sel_a});
    print_verdict();
  end
endmodule : ftc_regs_bench
